// *** rtl/vpsf_pkg.sv ***
package vpsf_pkg;

  // System clock and frame timing
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned FRAME_HZ     = 8_000;
  localparam int unsigned BCLK_128_HZ  = 128_000;
  localparam int unsigned BCLK_256_HZ  = 256_000;
  localparam int unsigned BCLK_512_HZ  = 512_000;

  // Half bit-clock periods in system cycles, rounded down
  localparam logic [8:0] HALF_128 = 9'(CLK_HZ / (2 * BCLK_128_HZ));
  localparam logic [8:0] HALF_256 = 9'(CLK_HZ / (2 * BCLK_256_HZ));
  localparam logic [8:0] HALF_512 = 9'(CLK_HZ / (2 * BCLK_512_HZ));

  // Last bit index of a master frame at each rate
  localparam logic [6:0] FLAST_128 = 7'(BCLK_128_HZ / FRAME_HZ - 1);
  localparam logic [6:0] FLAST_256 = 7'(BCLK_256_HZ / FRAME_HZ - 1);
  localparam logic [6:0] FLAST_512 = 7'(BCLK_512_HZ / FRAME_HZ - 1);

  // Slot geometry and long sync length
  localparam int unsigned SAMPLE_W   = 16;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [6:0]  LFS_BITS   = 7'h08;
  localparam logic [3:0]  POS_LAST16 = 4'hF;
  localparam logic [3:0]  POS_LAST8  = 4'h7;

  // Register offsets
  localparam logic [7:0] ADDR_CFG  = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;

  typedef enum logic [1:0] {
    VPSF_LIN13 = 2'b00,
    VPSF_LIN16 = 2'b01,
    VPSF_ULAW  = 2'b10,
    VPSF_ALAW  = 2'b11
  } vpsf_fmt_t;

  typedef enum logic [1:0] {
    VPSF_FILL_SIGN = 2'b00,
    VPSF_FILL_ZERO = 2'b01,
    VPSF_FILL_ATT  = 2'b10
  } vpsf_fill_t;

  typedef enum logic [1:0] {
    VPSF_R128 = 2'b00,
    VPSF_R256 = 2'b01,
    VPSF_R512 = 2'b10
  } vpsf_rate_t;

  typedef enum logic {
    LNK_IDLE = 1'b0,
    LNK_RUN  = 1'b1
  } vpsf_link_t;

  // Configuration word, bit 0 is rate[0]
  typedef struct packed {
    logic       master;
    logic       long_fs;
    logic       slot16;
    vpsf_fmt_t  fmt;
    logic       little;
    vpsf_fill_t fill;
    logic [2:0] gain;
    logic       mute;
    logic       fs_off;
    logic [3:0] slot_en;
    vpsf_rate_t rate;
  } vpsf_cfg_t;

  localparam int unsigned CFG_W = $bits(vpsf_cfg_t);
  localparam vpsf_cfg_t   CFG_RST = vpsf_cfg_t'(19'h00000);

  typedef struct packed {
    logic [1:0]  slot;
    logic [15:0] data;
  } vpsf_rx_t;

  typedef struct packed {
    logic       over;
    logic [1:0] slot;
    logic [3:0] pos;
  } vpsf_loc_t;

endpackage

// *** rtl/vpsf_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
module vpsf_fifo #(
  parameter int unsigned W = 16,
  parameter int unsigned D = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int unsigned AW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic         push;
  logic         pop;

  // Extra pointer bit tells full from empty
  assign o_valid = (wr_q != rd_q);
  assign o_ready = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;
  assign o_data  = mem_q[rd_q[AW-1:0]];

  // Pointers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  // Storage, no reset needed
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= i_data;
    end
  end
endmodule
`default_nettype wire

// *** rtl/vpsf_core.sv ***
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module vpsf_core (
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic [7:0]          i_addr,
  input  wire logic [31:0]         i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output logic [31:0]              o_rdata,
  input  wire logic                i_tx_valid,
  output logic                     o_tx_ready,
  input  wire logic [15:0]         i_tx_data,
  output logic                     o_rx_valid,
  output var vpsf_pkg::vpsf_rx_t   o_rx,
  input  wire logic                i_voice_bit_clock_alias,
  output logic                     o_voice_bit_clock_alias,
  output logic                     o_voice_bit_clock_alias_oe_n,
  input  wire logic                i_fsync,
  output logic                     o_fsync,
  output logic                     o_fsync_oe_n,
  input  wire logic                i_voice_serial_in,
  output logic                     o_voice_serial_out_alias,
  output logic                     o_voice_serial_out_alias_oe_n
);
  import vpsf_pkg::*;

  vpsf_cfg_t   cfg_q;
  vpsf_link_t  link_q;
  logic [2:0]  sy1_q;
  logic [2:0]  sy2_q;
  logic        bc_prev_q;
  logic        fs_prev_q;
  logic [8:0]  div_q;
  logic        mclk_q;
  logic        pend_q;
  logic [6:0]  bit_q;
  logic [15:0] tx_word_q;
  logic [15:0] rx_word_q;
  logic        underrun_q;
  logic        bclk_s;
  logic        fs_s;
  logic        din_s;
  logic        bc;
  logic        rise;
  logic        fall;
  logic        fs_rise;
  logic        imm;
  logic        launch;
  logic        start;
  logic        cfg_err;
  logic [8:0]  half;
  logic [6:0]  flast;
  logic [6:0]  nb;
  vpsf_loc_t   ln;
  vpsf_loc_t   lc;
  logic        run_n;
  logic        drive_n;
  logic        load;
  logic        fs_n;
  logic        fifo_valid;
  logic [15:0] fifo_data;
  logic [15:0] new_word;
  logic [15:0] src;
  logic [3:0]  tidx;
  logic [3:0]  ridx;
  logic        rx_sel;
  logic        rx_last;
  logic [15:0] rx_full;

  // Slot position of a bit index within the frame
  function automatic vpsf_loc_t locate(input logic [6:0] bi,
                                       input logic       s16);
    vpsf_loc_t l;
    l.over = s16 ? bi[6] : (bi[6] | bi[5]);
    l.slot = s16 ? bi[5:4] : bi[4:3];
    l.pos  = s16 ? bi[3:0] : {1'b0, bi[2:0]};
    return l;
  endfunction

  // Serial index of a slot position; LSB first when little
  function automatic logic [3:0] bidx(input logic [3:0] pos,
                                      input vpsf_cfg_t  c);
    return c.little ? pos : ((c.slot16 ? POS_LAST16 : POS_LAST8) - pos);
  endfunction

  // Sample to slot word: MSB aligned, spares in the low bits
  function automatic logic [15:0] pack(input logic [15:0] s,
                                       input vpsf_cfg_t   c);
    logic [2:0] f3;
    logic [7:0] f8;
    f3 = (c.fill == VPSF_FILL_SIGN) ? {3{s[12]}} :
         (c.fill == VPSF_FILL_ATT) ? c.gain : 3'h0;
    f8 = (c.fill == VPSF_FILL_SIGN) ? {8{s[7]}} :
         (c.fill == VPSF_FILL_ATT) ? {5'h00, c.gain} : 8'h00;
    if (!c.slot16) begin
      return {8'h00, s[7:0]};
    end
    unique case (c.fmt)
      VPSF_LIN16: return s;
      VPSF_LIN13: return {s[12:0], f3};
      VPSF_ULAW,
      VPSF_ALAW:  return {s[7:0], f8};
    endcase
  endfunction

  // Slot word back to a right-aligned sample
  function automatic logic [15:0] unpack(input logic [15:0] w,
                                         input vpsf_cfg_t   c);
    if (!c.slot16) begin
      return {8'h00, w[7:0]};
    end
    unique case (c.fmt)
      VPSF_LIN16: return w;
      VPSF_LIN13: return {{3{w[15]}}, w[15:3]};
      VPSF_ULAW,
      VPSF_ALAW:  return {8'h00, w[15:8]};
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Register port

  // Configuration, written whole
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cfg_q <= CFG_RST;
    end else if (i_wr && i_addr == ADDR_CFG) begin
      cfg_q <= vpsf_cfg_t'(i_wdata[CFG_W-1:0]);
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd && i_addr == ADDR_CFG) begin
      o_rdata <= {{(32 - CFG_W){1'b0}}, cfg_q};
    end else if (i_rd && i_addr == ADDR_STAT) begin
      o_rdata <= {29'h0000000, underrun_q, cfg_err, link_q};
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

  // Underrun is sticky; a new event beats the clear-on-read
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      underrun_q <= 1'b0;
    end else if (load && !fifo_valid) begin
      underrun_q <= 1'b1;
    end else if (i_rd && i_addr == ADDR_STAT) begin
      underrun_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge finding

  // Two flops on every pin; only the second stage is read
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sy1_q <= 3'h0;
      sy2_q <= 3'h0;
    end else begin
      sy1_q <= {i_fsync, i_voice_bit_clock_alias, i_voice_serial_in};
      sy2_q <= sy1_q;
    end
  end

  assign fs_s   = sy2_q[2];
  assign bclk_s = sy2_q[1];
  assign din_s  = sy2_q[0];

  // Edge history of the active bit clock and sync
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bc_prev_q <= 1'b0;
      fs_prev_q <= 1'b0;
    end else begin
      bc_prev_q <= bc;
      fs_prev_q <= fs_s;
    end
  end

  assign bc      = cfg_q.master ? mclk_q : bclk_s;
  assign rise    = bc & ~bc_prev_q;
  assign fall    = ~bc & bc_prev_q;
  assign fs_rise = fs_s & ~fs_prev_q;
  assign cfg_err = !cfg_q.slot16 &&
                   (cfg_q.fmt == VPSF_LIN13 || cfg_q.fmt == VPSF_LIN16);

  //////////////////////////////////////////////////////////////////////////
  // Master bit clock divider

  always_comb begin
    unique case (cfg_q.rate)
      VPSF_R128: begin
        half  = HALF_128;
        flast = FLAST_128;
      end
      VPSF_R256: begin
        half  = HALF_256;
        flast = FLAST_256;
      end
      default: begin
        half  = HALF_512;
        flast = FLAST_512;
      end
    endcase
  end

  // Rounded-down half period gives a slightly fast clock, never slow
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !cfg_q.master) begin
      div_q  <= 9'h000;
      mclk_q <= 1'b0;
    end else if (div_q == half - 9'h001) begin
      div_q  <= 9'h000;
      mclk_q <= ~mclk_q;
    end else begin
      div_q <= div_q + 9'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Frame timing

  // Long slave sync rising while the clock is high launches at once
  assign imm    = !cfg_q.master && cfg_q.long_fs && fs_rise && bc;
  assign launch = rise | imm;
  // A count left past the frame end (slave run, rate change) restarts
  assign start  = cfg_q.master ? (bit_q >= flast) : (pend_q | imm);
  assign nb     = start ? 7'h00 :
                  (bit_q == 7'h7F) ? bit_q : bit_q + 7'h01;
  assign ln     = locate(nb, cfg_q.slot16);
  assign run_n  = !ln.over && (start || link_q == LNK_RUN);
  assign drive_n = run_n && cfg_q.slot_en[ln.slot] && !cfg_err;
  assign load   = launch && drive_n && ln.pos == 4'h0;
  assign fs_n   = !cfg_q.fs_off && (cfg_q.long_fs ? (nb < LFS_BITS)
                                                  : (nb == flast));

  // Slave sync is caught on the clock edges that frame it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || cfg_q.master) begin
      pend_q <= 1'b0;
    end else if (cfg_q.long_fs && fs_rise && !bc) begin
      pend_q <= 1'b1;
    end else if (!cfg_q.long_fs && fall && fs_s) begin
      pend_q <= 1'b1;
    end else if (rise) begin
      pend_q <= 1'b0;
    end
  end

  // Bit counter and frame state advance on each launch
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bit_q  <= 7'h00;
      link_q <= LNK_IDLE;
    end else if (launch) begin
      bit_q  <= nb;
      link_q <= run_n ? LNK_RUN : LNK_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmit path

  vpsf_fifo #(
    .W (SAMPLE_W),
    .D (FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_valid (i_tx_valid),
    .o_ready (o_tx_ready),
    .i_data  (i_tx_data),
    .o_valid (fifo_valid),
    .i_ready (load),
    .o_data  (fifo_data)
  );

  // An empty queue sends silence rather than stale data
  assign new_word = pack(fifo_valid ? fifo_data : 16'h0000,
                         cfg_q);
  assign src      = (ln.pos == 4'h0) ? new_word : tx_word_q;
  assign tidx     = bidx(ln.pos, cfg_q);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_word_q <= 16'h0000;
    end else if (load) begin
      tx_word_q <= new_word;
    end
  end

  // Serial out changes on rising edges or a late long slave sync; released when unselected
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_voice_serial_out_alias      <= 1'b0;
      o_voice_serial_out_alias_oe_n <= 1'b1;
    end else if (launch) begin
      o_voice_serial_out_alias      <= !cfg_q.mute && src[tidx];
      o_voice_serial_out_alias_oe_n <= !drive_n;
    end
  end

  // Master drives clock and sync; sync held low when suppressed
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_fsync                      <= 1'b0;
      o_fsync_oe_n                 <= 1'b1;
      o_voice_bit_clock_alias      <= 1'b0;
      o_voice_bit_clock_alias_oe_n <= 1'b1;
    end else begin
      o_fsync_oe_n                 <= !cfg_q.master;
      o_voice_bit_clock_alias      <= mclk_q;
      o_voice_bit_clock_alias_oe_n <= !cfg_q.master;
      if (!cfg_q.master) begin
        o_fsync <= 1'b0;
      end else if (launch) begin
        o_fsync <= fs_n;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receive path

  assign lc      = locate(bit_q, cfg_q.slot16);
  assign rx_sel  = link_q == LNK_RUN && cfg_q.slot_en[lc.slot] && !cfg_err;
  assign ridx    = bidx(lc.pos, cfg_q);
  assign rx_last = lc.pos == (cfg_q.slot16 ? POS_LAST16 : POS_LAST8);

  always_comb begin
    rx_full       = rx_word_q;
    rx_full[ridx] = din_s;
  end

  // Input bits are taken on falling edges, one sample per slot
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_word_q  <= 16'h0000;
      o_rx_valid <= 1'b0;
      o_rx       <= '0;
    end else begin
      o_rx_valid <= 1'b0;
      if (fall && rx_sel) begin
        rx_word_q <= rx_full;
        if (rx_last) begin
          o_rx_valid <= 1'b1;
          o_rx       <= '{slot: lc.slot, data: unpack(rx_full, cfg_q)};
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_mute;
    launch && cfg_q.mute |=> !o_voice_serial_out_alias;
  endproperty
  a_mute: assert property (p_mute)
    else $error("serial out not zero while muted");

  property p_fs_off;
    cfg_q.master && cfg_q.fs_off && launch |=> !o_fsync;
  endproperty
  a_fs_off: assert property (p_fs_off)
    else $error("sync driven while suppressed");

  property p_unsel;
    launch && (ln.over || !cfg_q.slot_en[ln.slot])
      |=> o_voice_serial_out_alias_oe_n;
  endproperty
  a_unsel: assert property (p_unsel)
    else $error("output driven in unselected slot");

  property p_cfg_err;
    launch && cfg_err |=> o_voice_serial_out_alias_oe_n;
  endproperty
  a_cfg_err: assert property (p_cfg_err)
    else $error("illegal slot and format pair transmitted");

  property p_long_len;
    cfg_q.master && cfg_q.long_fs && $fell(o_fsync)
      |-> bit_q == LFS_BITS && $past(cfg_q.long_fs);
  endproperty
  a_long_len: assert property (p_long_len)
    else $error("long sync not eight bits");

  property p_short_end;
    cfg_q.master && !cfg_q.long_fs && $fell(o_fsync) |-> bit_q == 7'h00;
  endproperty
  a_short_end: assert property (p_short_end)
    else $error("short sync does not end at word start");

  property p_div;
    cfg_q.master && $changed(mclk_q)
      |-> $past(div_q) == $past(half) - 9'h001;
  endproperty
  a_div: assert property (p_div)
    else $error("bit clock half period wrong");

  property p_rx_fall;
    o_rx_valid |-> $past(fall) && !$past(bc);
  endproperty
  a_rx_fall: assert property (p_rx_fall)
    else $error("sample completed off a falling edge");

  property p_imm;
    !cfg_q.master && cfg_q.long_fs && fs_rise && bc |=> bit_q == 7'h00;
  endproperty
  a_imm: assert property (p_imm)
    else $error("first bit not launched at late sync edge");

  property p_gain;
    load && cfg_q.slot16 && cfg_q.fmt == VPSF_LIN13 &&
      cfg_q.fill == VPSF_FILL_ATT |=> tx_word_q[2:0] == $past(cfg_q.gain);
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain code missing from spare bits");
endmodule
`default_nettype wire

// *** verif/vpsf_codec.sv ***
`timescale 1ns/100ps
`default_nettype none
// Far-side codec: supplies slave timing, sends and records serial data
// Two-clock-per-bit timing is not modelled here
module vpsf_codec (
  output logic      o_bclk,
  output logic      o_fsync,
  output logic      o_sdata,
  input  wire logic i_sdata,
  input  wire logic i_sdata_oe_n
);
  localparam realtime HALF = 62.5; // Above the slave range, harder case

  // Clock stands low between frames
  initial begin
    o_bclk = 1'b0;
    o_fsync = 1'b0;
    o_sdata = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One 64-bit frame after a lead-in cycle that carries the short sync;
  // a late long sync rises instead while bit 0's clock is already high
  task automatic frame(input logic lfs, input logic late,
                       input logic [63:0] din,
                       output logic [63:0] dout, output logic [63:0] drv);
    if (!late) begin
      o_fsync = !lfs;
      o_bclk = 1'b1;
      #HALF;
      o_bclk = 1'b0;
      #(HALF / 2);
      if (lfs) o_fsync = 1'b1; // Rises while clock low
      #(HALF / 2);
    end
    for (int i = 0; i < 64; i++) begin
      o_bclk = 1'b1;
      o_sdata = din[63-i]; // Launch on rising edge
      if (i == (lfs ? 8 : 0)) o_fsync = 1'b0;
      if (late && i == 0) begin
        #(HALF / 4);
        o_fsync = 1'b1; // Sync is the later edge here
        #(HALF * 3 / 4);
      end else begin
        #HALF;
      end
      o_bclk = 1'b0;
      // Released line reads inverted, capture on falling edge
      dout[63-i] = i_sdata ^ i_sdata_oe_n;
      drv[63-i] = !i_sdata_oe_n;
      #HALF;
    end
    // Codec data line inverts after the frame, so stale data never passes for fresh
    o_sdata = !o_sdata;
  endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
  import vpsf_pkg::*;

  typedef struct packed {
    vpsf_fmt_t   fmt;
    vpsf_fill_t  fill;
    logic        mute;
    logic [15:0] tx;
    logic [15:0] out;
    logic [15:0] rx;
  } vpsf_row_t;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0, rd = 1'b0, tx_valid = 1'b0;
  logic [15:0] tx_data = 16'h0;
  logic [31:0] rdata, rv;
  logic        tx_ready, rx_valid, bo, bo_oe_n, fo, fo_oe_n;
  logic        so, so_oe_n, cb, cf, cs, late = 1'b0;
  vpsf_rx_t    rx;
  vpsf_cfg_t   cfg = CFG_RST;
  vpsf_rx_t    rxq[$];
  int          n_mismatch = 0, n_tests = 0, cyc = 0;
  int          hf[3] = '{HALF_128, HALF_256, HALF_512};
  wire         bclk_w = bo_oe_n ? cb : bo;
  wire         fs_w = fo_oe_n ? cf : fo;
  // Sample, fill and mute cases on slot 0, gain code 5
  vpsf_row_t   rows[6] = '{
    '{VPSF_LIN13, VPSF_FILL_SIGN, 1'b0, 16'h1A5C, 16'hD2E7, 16'hF4B4},
    '{VPSF_LIN13, VPSF_FILL_ZERO, 1'b0, 16'h1A5C, 16'hD2E0, 16'hF4B4},
    '{VPSF_LIN13, VPSF_FILL_ATT, 1'b0, 16'h1A5C, 16'hD2E5, 16'hF4B4},
    '{VPSF_ULAW, VPSF_FILL_SIGN, 1'b0, 16'h00C3, 16'hC3FF, 16'h00A5},
    '{VPSF_ALAW, VPSF_FILL_SIGN, 1'b0, 16'h003C, 16'h3C00, 16'h00A5},
    '{VPSF_LIN16, VPSF_FILL_ZERO, 1'b1, 16'hFFFF, 16'h0000, 16'hA5A5}};

  vpsf_core dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_tx_valid(tx_valid),
    .o_tx_ready(tx_ready), .i_tx_data(tx_data), .o_rx_valid(rx_valid),
    .o_rx(rx), .i_voice_bit_clock_alias(bclk_w),
    .o_voice_bit_clock_alias(bo), .o_voice_bit_clock_alias_oe_n(bo_oe_n),
    .i_fsync(fs_w), .o_fsync(fo), .o_fsync_oe_n(fo_oe_n),
    .i_voice_serial_in(cs), .o_voice_serial_out_alias(so),
    .o_voice_serial_out_alias_oe_n(so_oe_n));
  vpsf_codec codec (
    .o_bclk(cb), .o_fsync(cf), .o_sdata(cs), .i_sdata(so),
    .i_sdata_oe_n(so_oe_n));

  always #4 clk = ~clk;

  // Cycle count and received samples; the pulse lasts one cycle only
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rx_valid) rxq.push_back(rx);
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Idle cycle after a write keeps strobes from merging
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  task automatic push(input logic [15:0] d);
    tx_valid <= 1'b1;
    tx_data <= d;
    @(posedge clk);
    tx_valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rx_chk(input vpsf_rx_t e);
    vpsf_rx_t s;
    s = 'x;
    if (rxq.size() > 0) s = rxq.pop_front();
    chk("rx sample", s, e);
  endtask

  // Offset from the clock edge so link and system edges rarely meet
  task automatic run_frame(input logic [63:0] din, eo, ed);
    logic [63:0] dout, drv;
    #3;
    codec.frame(cfg.long_fs, late, din, dout, drv);
    chk("line driven", drv, ed);
    chk("line data", dout & ed, eo);
    @(posedge clk);
  endtask

  // Wait for a master sync rise, then time its high phase
  task automatic sync_meas(output int t, output int h);
    int n;
    n = 0;
    while (fo !== 1'b1 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    t = cyc;
    h = 0;
    while (fo === 1'b1 && h < 40000) begin
      @(posedge clk);
      h++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end

  initial begin
    int t0, t1, h, tog, hi;
    logic pb;
    logic [63:0] e;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("oe idle", {bo_oe_n, fo_oe_n, so_oe_n}, 3'h7);
    rreg(ADDR_STAT, rv);
    chk("stat reset", rv, 32'h2);
    rreg(8'h08, rv);
    chk("unmapped", rv, 32'h0);
    // Two of four slots, short sync, big endian
    cfg.slot16 = 1'b1;
    cfg.fmt = VPSF_LIN16;
    cfg.gain = 3'h5;
    cfg.slot_en = 4'h5;
    wreg(ADDR_CFG, 32'(cfg));
    rreg(ADDR_CFG, rv);
    chk("cfg", rv, 32'(cfg));
    push(16'hBEEF);
    push(16'hC0DE);
    run_frame(64'hA5A5_1111_5A5A_2222, 64'hBEEF_0000_C0DE_0000,
              64'hFFFF_0000_FFFF_0000);
    rx_chk({2'h0, 16'hA5A5});
    rx_chk({2'h2, 16'h5A5A});
    // Last slot, little endian, long sync
    cfg.little = 1'b1;
    cfg.long_fs = 1'b1;
    cfg.slot_en = 4'h8;
    wreg(ADDR_CFG, 32'(cfg));
    push(16'h1234);
    run_frame(64'hF00D, 64'h2C48, 64'hFFFF);
    rx_chk({2'h3, 16'hB00F});
    // Sync rising while the clock is high launches bit 0 at once
    cfg.slot_en = 4'h9;
    wreg(ADDR_CFG, 32'(cfg));
    push(16'h8001);
    push(16'h1234);
    late = 1'b1;
    run_frame(64'hC000_0000_0000_F00D, 64'h8001_0000_0000_2C48,
              64'hFFFF_0000_0000_FFFF);
    late = 1'b0;
    rx_chk({2'h0, 16'h0003});
    rx_chk({2'h3, 16'hB00F});
    cfg.little = 1'b0;
    cfg.long_fs = 1'b0;
    cfg.slot_en = 4'h1;
    foreach (rows[i]) begin
      cfg.fmt = rows[i].fmt;
      cfg.fill = rows[i].fill;
      cfg.mute = rows[i].mute;
      wreg(ADDR_CFG, 32'(cfg));
      push(rows[i].tx);
      run_frame({16'hA5A5, 48'h0}, {rows[i].out, 48'h0},
                {16'hFFFF, 48'h0});
      rx_chk({2'h0, rows[i].rx});
    end
    // Fill the buffer, drain it over 8-clock slots, then run dry
    cfg.mute = 1'b0;
    cfg.slot16 = 1'b0;
    cfg.fmt = VPSF_ULAW;
    cfg.slot_en = 4'hF;
    wreg(ADDR_CFG, 32'(cfg));
    for (int i = 0; i < 8; i++) begin
      push(16'(8'h11 * (i + 1)));
      chk("tx ready", tx_ready, i < 7);
    end
    for (int k = 0; k < 3; k++) begin
      e = 64'h0;
      for (int s = 0; s < 4; s++)
        if (k < 2) e[63-8*s -: 8] = 8'(8'h11 * (4 * k + s + 1));
      run_frame(64'h0102_0304_0506_0708, e,
                64'hFFFF_FFFF_0000_0000);
      for (int s = 0; s < 4; s++)
        rx_chk({2'(s), 16'(s + 1)});
      rreg(ADDR_STAT, rv);
      chk("underrun", rv & 32'h6, k == 2 ? 32'h4 : 32'h0);
    end
    rreg(ADDR_STAT, rv);
    chk("underrun clear", rv & 32'h6, 32'h0);
    // Short slot with a linear format carries nothing
    cfg.fmt = VPSF_LIN16;
    cfg.slot_en = 4'h1;
    wreg(ADDR_CFG, 32'(cfg));
    run_frame(64'hFFFF_0000_0000_0000, 64'h0, 64'h0);
    rreg(ADDR_STAT, rv);
    chk("cfg error", rv & 32'h2, 32'h2);
    chk("rx count", rxq.size(), 0);
    // Master timing at every rate; the codec stands still
    cfg = CFG_RST;
    cfg.master = 1'b1;
    cfg.long_fs = 1'b1;
    cfg.slot16 = 1'b1;
    for (int r = 0; r < 3; r++) begin
      cfg.rate = vpsf_rate_t'(r);
      wreg(ADDR_CFG, 32'(cfg));
      sync_meas(t0, h);
      chk("sync bits", (h + hf[r]) / (2 * hf[r]), 8);
      chk("master oe", {bo_oe_n, fo_oe_n}, 2'h0);
    end
    sync_meas(t1, h);
    chk("frame bits", (t1 - t0 + hf[2]) / (2 * hf[2]), 64);
    cfg.long_fs = 1'b0;
    wreg(ADDR_CFG, 32'(cfg));
    sync_meas(t0, h);
    chk("short sync bits", (h + hf[2]) / (2 * hf[2]), 1);
    cfg.fs_off = 1'b1;
    wreg(ADDR_CFG, 32'(cfg));
    hi = 0;
    tog = 0;
    pb = bo;
    repeat (12500) begin
      @(posedge clk);
      hi += (fo !== 1'b0);
      tog += (bo !== pb);
      pb = bo;
    end
    chk("sync held", hi, 0);
    chk("clock runs", tog > 100, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
